/* File: inc/panel_pkg.sv */
// Purpose: constants and carriers of the front panel text display and keys
// Assumes: 100 MHz clk, 32-bit register port with byte addresses
// Notes: text words carry a logical port number beside the character
// Overview of operation
// - The display holds two rows of sixteen character cells.
// - Text sent to logical port 8 lands on the display, any other port goes to the serial output.
// - A substitution code in the text expands to the value register printed as two hex digits.
// - Code 0x0C puts the cursor at column one of the top row at once, then blanks every cell over 32 cycles.
// - Code 0x0D puts the cursor at column one of the top row and keeps the cells.
// - Code 0x0A puts the cursor at column one of the bottom row and keeps the cells.
// - A key word shows the four keys, bit 0 the first key and bit 3 the fourth, set while held.
// - Four key flags, one per key, read on while the key is pressed.
// - A programming download is accepted only when its station number equals the set station.
// - The station number is eight bits wide, for 256 units.
// - With monitor mode on, downloads and facility changes are refused and only observation passes.
package panel_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int ROWS = 2;
	localparam int COLS = 16;
	localparam int CELLS = ROWS * COLS;
	localparam int STATION_W = 8;
	localparam int KEYS = 4;
	// ************************************
	// register byte offsets
	// ************************************
	localparam logic [ADDR_W-1:0] OFS_TEXT = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_VALUE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STATION = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CELL_IDX = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CELL_DATA = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_KEYS = 8'h1C;
	// ************************************
	// fields and codes
	// ************************************
	localparam int CFG_MONITOR_BIT = 0;
	localparam int STAT_OVERRUN_BIT = 8;
	localparam logic [3:0] DISP_PORT = 4'h8;
	localparam logic [7:0] CC_CLEAR = 8'h0C;
	localparam logic [7:0] CC_HOME = 8'h0D;
	localparam logic [7:0] CC_LINE2 = 8'h0A;
	localparam logic [7:0] CC_SUBST = 8'h01;
	localparam logic [7:0] CH_BLANK = 8'h20;
	localparam logic [7:0] CH_FIRST_PRINT = 8'h20;
	localparam logic [7:0] CH_DEL = 8'h7F;
	localparam logic [7:0] STATION_RESET = 8'h00;
	// ************************************
	// timing
	// ************************************
	localparam int CLK_MHZ = 100;
	localparam int DEB_PERIOD_US = 1000;
	localparam int DEB_CYC = DEB_PERIOD_US * CLK_MHZ;
	localparam int DEB_SAMPLES = 4;
	typedef struct packed {
		logic [3:0] port;
		logic [7:0] ch;
	} text_cmd_t;
	typedef struct packed {
		logic req;
		logic [STATION_W-1:0] station;
		logic modify;
	} prog_req_t;
	typedef enum logic [1:0] {T_IDLE, T_HEXLO, T_CLEAR} text_state_t;
endpackage

/* File: core/front_panel_text_display_keys.sv */
// Purpose: panel text display, key debouncing, station and monitor gate
// Assumes: keys are asynchronous pins, program requests are on clk
// Notes: writes to the text register while busy are dropped and flagged
`timescale 1ns/10ps
module front_panel_text_display_keys #(
	parameter int DEB_CYCLES = panel_pkg::DEB_CYC,
	parameter int DEB_COUNT = panel_pkg::DEB_SAMPLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [panel_pkg::ADDR_W-1:0] addr,
	input wire logic [panel_pkg::DATA_W-1:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [panel_pkg::DATA_W-1:0] rdData,
	input wire logic firstPushKey,
	input wire logic secondPushKey,
	input wire logic thirdPushKey,
	input wire logic fourthPushKey,
	output logic firstKeyFlag,
	output logic secondKeyFlag,
	output logic thirdKeyFlag,
	output logic fourthKeyFlag,
	input wire panel_pkg::prog_req_t prog,
	output logic progAccept,
	output logic progRefuse,
	output logic serValid,
	output logic [3:0] serPort,
	output logic [7:0] serData,
	output logic cellWe,
	output logic [4:0] cellIdx,
	output logic [7:0] cellChar
);
	import panel_pkg::*;
	function automatic logic [7:0] hexChar(input logic [3:0] n);
		hexChar = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction
	// ************************************
	// text path
	// ************************************
	logic [7:0] dispMem [CELLS];
	text_state_t state_ff, nxt_state;
	logic row_ff, nxt_row;
	logic [4:0] col_ff, nxt_col;
	logic [4:0] clrIdx_ff, nxt_clrIdx;
	logic [7:0] value_ff, nxt_value;
	logic overrun_ff, nxt_overrun;
	logic serValid_ff, nxt_serValid;
	logic [3:0] serPort_ff, nxt_serPort;
	logic [7:0] serData_ff, nxt_serData, memChar, putChar;
	logic memWe, doPut, txtWr;
	logic [4:0] memIdx;
	text_cmd_t cmd;
	assign txtWr = wrStb && (addr == OFS_TEXT);
	assign cmd = text_cmd_t'(wrData[11:0]);
	always_comb begin
		nxt_state = state_ff;
		nxt_row = row_ff;
		nxt_col = col_ff;
		nxt_clrIdx = clrIdx_ff;
		nxt_value = value_ff;
		nxt_overrun = overrun_ff;
		nxt_serValid = 1'b0;
		nxt_serPort = serPort_ff;
		nxt_serData = serData_ff;
		memWe = 1'b0;
		memIdx = 5'h00;
		memChar = CH_BLANK;
		doPut = 1'b0;
		putChar = CH_BLANK;
		if (wrStb && addr == OFS_VALUE) begin
			nxt_value = wrData[7:0];
		end
		// write-one clears, a new overrun in the same cycle wins
		if (wrStb && addr == OFS_STATUS && wrData[STAT_OVERRUN_BIT]) begin
			nxt_overrun = 1'b0;
		end
		if (txtWr && state_ff != T_IDLE) begin
			nxt_overrun = 1'b1;
		end
		unique case (state_ff)
			T_IDLE: begin
				if (txtWr && cmd.port != DISP_PORT) begin
					nxt_serValid = 1'b1;
					nxt_serPort = cmd.port;
					nxt_serData = cmd.ch;
				end else if (txtWr) begin
					unique case (cmd.ch)
						CC_CLEAR: begin
							nxt_state = T_CLEAR;
							nxt_clrIdx = 5'h00;
							nxt_row = 1'b0;
							nxt_col = 5'h00;
						end
						CC_HOME: begin
							nxt_row = 1'b0;
							nxt_col = 5'h00;
						end
						CC_LINE2: begin
							nxt_row = 1'b1;
							nxt_col = 5'h00;
						end
						CC_SUBST: begin
							doPut = 1'b1;
							putChar = hexChar(value_ff[7:4]);
							nxt_state = T_HEXLO;
						end
						default: begin
							doPut = (cmd.ch >= CH_FIRST_PRINT) && (cmd.ch != CH_DEL) && !cmd.ch[7];
							putChar = cmd.ch;
						end
					endcase
				end
			end
			T_HEXLO: begin
				doPut = 1'b1;
				putChar = hexChar(value_ff[3:0]);
				nxt_state = T_IDLE;
			end
			T_CLEAR: begin
				memWe = 1'b1;
				memIdx = clrIdx_ff;
				memChar = CH_BLANK;
				nxt_clrIdx = clrIdx_ff + 5'h01;
				if (clrIdx_ff == 5'(CELLS - 1)) begin
					nxt_state = T_IDLE;
				end
			end
		endcase
		// past the last column the character is dropped
		if (doPut && col_ff < 5'(COLS)) begin
			memWe = 1'b1;
			memIdx = {row_ff, col_ff[3:0]};
			memChar = putChar;
			nxt_col = col_ff + 5'h01;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			state_ff <= T_IDLE;
			row_ff <= 1'b0;
			col_ff <= 5'h00;
			clrIdx_ff <= 5'h00;
			value_ff <= 8'h00;
			overrun_ff <= 1'b0;
			serValid_ff <= 1'b0;
			serPort_ff <= 4'h0;
			serData_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			row_ff <= nxt_row;
			col_ff <= nxt_col;
			clrIdx_ff <= nxt_clrIdx;
			value_ff <= nxt_value;
			overrun_ff <= nxt_overrun;
			serValid_ff <= nxt_serValid;
			serPort_ff <= nxt_serPort;
			serData_ff <= nxt_serData;
		end
	end
	// cell contents survive reset, as an lcd would; software clears with 0x0C
	always_ff @(posedge clk) begin
		if (memWe) begin
			dispMem[memIdx] <= memChar;
		end
	end
	logic cellWe_ff, nxt_cellWe;
	logic [4:0] cellIdx_ff, nxt_cellIdx;
	logic [7:0] cellChar_ff, nxt_cellChar;
	always_comb begin
		nxt_cellWe = memWe;
		nxt_cellIdx = memWe ? memIdx : cellIdx_ff;
		nxt_cellChar = memWe ? memChar : cellChar_ff;
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			cellWe_ff <= 1'b0;
			cellIdx_ff <= 5'h00;
			cellChar_ff <= CH_BLANK;
		end else begin
			cellWe_ff <= nxt_cellWe;
			cellIdx_ff <= nxt_cellIdx;
			cellChar_ff <= nxt_cellChar;
		end
	end
	// ************************************
	// key debouncing
	// ************************************
	logic [KEYS-1:0] keyRaw;
	logic [KEYS-1:0] keySync1_ff, keySync2_ff;
	logic [KEYS-1:0] keyState_ff;
	logic [$clog2(DEB_CYCLES)-1:0] tickCnt_ff, nxt_tickCnt;
	logic tick_ff, nxt_tick;
	assign keyRaw = {fourthPushKey, thirdPushKey, secondPushKey, firstPushKey};
	always_ff @(posedge clk) begin
		if (srst) begin
			keySync1_ff <= '0;
			keySync2_ff <= '0;
		end else begin
			keySync1_ff <= keyRaw;
			keySync2_ff <= keySync1_ff;
		end
	end
	// a slow sample tick rejects bounce far better than a per-clock filter
	always_comb begin
		nxt_tick = 1'b0;
		nxt_tickCnt = tickCnt_ff + 1'b1;
		if (tickCnt_ff == ($clog2(DEB_CYCLES))'(DEB_CYCLES - 1)) begin
			nxt_tickCnt = '0;
			nxt_tick = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			tickCnt_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			tickCnt_ff <= nxt_tickCnt;
			tick_ff <= nxt_tick;
		end
	end
	for (genvar k = 0; k < KEYS; k++) begin : g_key
		logic [3:0] cnt_ff, nxt_cnt;
		logic st_ff, nxt_st;
		always_comb begin
			nxt_cnt = cnt_ff;
			nxt_st = st_ff;
			if (tick_ff) begin
				if (keySync2_ff[k] == st_ff) begin
					nxt_cnt = 4'h0;
				end else if (cnt_ff == 4'(DEB_COUNT - 1)) begin
					nxt_cnt = 4'h0;
					nxt_st = keySync2_ff[k];
				end else begin
					nxt_cnt = cnt_ff + 4'h1;
				end
			end
		end
		always_ff @(posedge clk) begin
			if (srst) begin
				cnt_ff <= 4'h0;
				st_ff <= 1'b0;
			end else begin
				cnt_ff <= nxt_cnt;
				st_ff <= nxt_st;
			end
		end
		assign keyState_ff[k] = st_ff;
	end
	assign firstKeyFlag = keyState_ff[0];
	assign secondKeyFlag = keyState_ff[1];
	assign thirdKeyFlag = keyState_ff[2];
	assign fourthKeyFlag = keyState_ff[3];
	// ************************************
	// station and monitor gate
	// ************************************
	logic [STATION_W-1:0] station_ff, nxt_station;
	logic monitor_ff, nxt_monitor;
	logic progAccept_ff, nxt_progAccept;
	logic progRefuse_ff, nxt_progRefuse;
	logic stnMatch;
	assign stnMatch = prog.station == station_ff;
	always_comb begin
		nxt_station = station_ff;
		nxt_monitor = monitor_ff;
		if (wrStb && addr == OFS_STATION) begin
			nxt_station = wrData[STATION_W-1:0];
		end
		if (wrStb && addr == OFS_CONFIG) begin
			nxt_monitor = wrData[CFG_MONITOR_BIT];
		end
		nxt_progAccept = prog.req && stnMatch && !(monitor_ff && prog.modify);
		nxt_progRefuse = prog.req && !nxt_progAccept;
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			station_ff <= STATION_RESET;
			monitor_ff <= 1'b0;
			progAccept_ff <= 1'b0;
			progRefuse_ff <= 1'b0;
		end else begin
			station_ff <= nxt_station;
			monitor_ff <= nxt_monitor;
			progAccept_ff <= nxt_progAccept;
			progRefuse_ff <= nxt_progRefuse;
		end
	end
	// ************************************
	// register read port
	// ************************************
	logic [4:0] cellSel_ff, nxt_cellSel;
	logic [DATA_W-1:0] rdData_ff, nxt_rdData;
	always_comb begin
		nxt_cellSel = cellSel_ff;
		if (wrStb && addr == OFS_CELL_IDX) begin
			nxt_cellSel = wrData[4:0];
		end
		nxt_rdData = '0;
		if (rdStb) begin
			unique case (addr)
				OFS_VALUE: nxt_rdData = {24'h0, value_ff};
				OFS_STATION: nxt_rdData = {24'h0, station_ff};
				OFS_CONFIG: nxt_rdData = {31'h0, monitor_ff};
				OFS_STATUS: nxt_rdData = {23'h0, overrun_ff, state_ff != T_IDLE, row_ff, 1'b0, col_ff};
				OFS_CELL_IDX: nxt_rdData = {27'h0, cellSel_ff};
				OFS_CELL_DATA: nxt_rdData = {24'h0, dispMem[cellSel_ff]};
				OFS_KEYS: nxt_rdData = {28'h0, keyState_ff};
				default: nxt_rdData = '0;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			cellSel_ff <= 5'h00;
			rdData_ff <= '0;
		end else begin
			cellSel_ff <= nxt_cellSel;
			rdData_ff <= nxt_rdData;
		end
	end
	assign rdData = rdData_ff;
	assign progAccept = progAccept_ff;
	assign progRefuse = progRefuse_ff;
	assign serValid = serValid_ff;
	assign serPort = serPort_ff;
	assign serData = serData_ff;
	assign cellWe = cellWe_ff;
	assign cellIdx = cellIdx_ff;
	assign cellChar = cellChar_ff;
	// ************************************
	// checks
	// ************************************
	wire logic dispCmd = txtWr && state_ff == T_IDLE && cmd.port == DISP_PORT;
	clear_blanks_a: assert property (@(posedge clk) disable iff (srst)
		dispCmd && cmd.ch == CC_CLEAR |=> !cellWe ##1 (cellWe && cellChar == CH_BLANK)[*8])
		else $error("clear does not blank cells");
	clear_home_a: assert property (@(posedge clk) disable iff (srst)
		dispCmd && cmd.ch == CC_CLEAR |=> row_ff == 1'b0 && col_ff == 5'h00 ##32 state_ff == T_IDLE)
		else $error("clear sequence length or cursor wrong");
	home_cursor_a: assert property (@(posedge clk) disable iff (srst)
		dispCmd && cmd.ch == CC_HOME |=> row_ff == 1'b0 && col_ff == 5'h00 && !cellWe)
		else $error("home code misbehaves");
	line_two_a: assert property (@(posedge clk) disable iff (srst)
		dispCmd && cmd.ch == CC_LINE2 |=> row_ff == 1'b1 && col_ff == 5'h00 && !cellWe)
		else $error("second line code misbehaves");
	put_advance_a: assert property (@(posedge clk) disable iff (srst)
		dispCmd && cmd.ch == 8'h41 && col_ff < 5'h10
		|=> col_ff == $past(col_ff) + 5'h01 && cellWe && cellChar == 8'h41)
		else $error("character not placed or cursor not advanced");
	col_limit_a: assert property (@(posedge clk) disable iff (srst)
		col_ff <= 5'h10 && !(memWe && state_ff == T_IDLE && col_ff == 5'h10))
		else $error("cursor or write beyond last column");
	serial_route_a: assert property (@(posedge clk) disable iff (srst)
		txtWr && state_ff == T_IDLE && cmd.port != DISP_PORT |=> serValid && serData == $past(cmd.ch) && !cellWe)
		else $error("non display port text misrouted");
	subst_hex_a: assert property (@(posedge clk) disable iff (srst)
		dispCmd && cmd.ch == CC_SUBST && col_ff < 5'h0F
		|=> cellChar == hexChar($past(value_ff[7:4])) ##1 cellWe && cellChar == hexChar(value_ff[3:0]))
		else $error("substitution not expanded");
	monitor_gate_a: assert property (@(posedge clk) disable iff (srst)
		prog.req && monitor_ff && prog.modify |=> progRefuse && !progAccept)
		else $error("modify passed in monitor mode");
	station_gate_a: assert property (@(posedge clk) disable iff (srst)
		prog.req && prog.station != station_ff |=> !progAccept && progRefuse)
		else $error("foreign station accepted");
	key_tick_a: assert property (@(posedge clk) disable iff (srst)
		!tick_ff |=> $stable(keyState_ff))
		else $error("key flags moved off sample tick");
endmodule // front_panel_text_display_keys

/* File: verification/tb_front_panel_text_display_keys.sv */
// Purpose: self-checking bench of the front panel text display and keys
// Assumes: debounce shortened to 8-cycle ticks and 4 samples
// Notes: every scenario drives the ports and judges the answers itself
`timescale 1ns/10ps
module tb_front_panel_text_display_keys;
	import panel_pkg::*;
	// ****************
	// signals
	// ****************
	logic clk, srst, wrStb, rdStb;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wrData, rdData, d;
	logic [3:0] key, flag, serPort;
	prog_req_t prog;
	logic progAccept, progRefuse, serValid, cellWe;
	logic [7:0] serData, cellChar;
	logic [4:0] cellIdx;
	logic [12:0] q[$];
	int errors, cmp_count;
	// ****************
	// clock and block
	// ****************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	front_panel_text_display_keys #(.DEB_CYCLES(8), .DEB_COUNT(4)) u_dut (.clk(clk), .srst(srst),
		.addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.firstPushKey(key[0]), .secondPushKey(key[1]), .thirdPushKey(key[2]), .fourthPushKey(key[3]),
		.firstKeyFlag(flag[0]), .secondKeyFlag(flag[1]), .thirdKeyFlag(flag[2]), .fourthKeyFlag(flag[3]),
		.prog(prog), .progAccept(progAccept), .progRefuse(progRefuse), .serValid(serValid),
		.serPort(serPort), .serData(serData), .cellWe(cellWe), .cellIdx(cellIdx), .cellChar(cellChar));
	// ****************
	// shared tasks
	// ****************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %0h seen %0h", n, e, g);
		end
	endtask
	// returns just after the edge that took the write, so one-cycle results can be sampled
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wrData <= v;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1;
		d = rdData;
	endtask
	task automatic grab(input int n);
		q.delete();
		repeat (n) begin
			if (cellWe === 1'b1) q.push_back({cellIdx, cellChar});
			@(posedge clk);
			#1;
		end
	endtask
	task automatic pg(input logic [7:0] s, input logic m, input logic acc);
		@(posedge clk);
		prog <= '{req: 1'b1, station: s, modify: m};
		@(posedge clk);
		prog.req <= 1'b0;
		#1;
		chk("progAccept", acc, progAccept);
		chk("progRefuse", !acc, progRefuse);
	endtask
	task automatic end_of_test;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_reset;
		chk("cellChar", 32'h20, cellChar);
		chk("flags", 32'h0, flag);
		rd(8'h40);
		chk("unmapped", 32'h0, d);
	endtask
	task automatic t_row;
		wr(OFS_TEXT, 32'h80D);
		for (int i = 0; i < 17; i++) begin
			wr(OFS_TEXT, 32'h840 + i);
			grab(1);
			chk("cellWe", i < 16, q.size());
			if (i < 16) chk("cell", {i[4:0], 8'h40 + i[7:0]}, q[0]);
		end
		rd(OFS_STATUS);
		chk("col", 32'h10, d[4:0]);
	endtask
	task automatic t_cursor;
		wr(OFS_TEXT, 32'h80A);
		wr(OFS_TEXT, 32'h85A);
		grab(1);
		chk("line2", {5'h10, 8'h5A}, q[0]);
		wr(OFS_TEXT, 32'h80D);
		wr(OFS_TEXT, 32'h859);
		grab(1);
		chk("home", {5'h00, 8'h59}, q[0]);
		wr(OFS_CELL_IDX, 32'h10);
		rd(OFS_CELL_DATA);
		chk("kept16", 32'h5A, d);
		wr(OFS_CELL_IDX, 32'h01);
		rd(OFS_CELL_DATA);
		chk("kept1", 32'h41, d);
	endtask
	task automatic t_serial;
		for (int p = 0; p < 16; p++) begin
			wr(OFS_TEXT, {20'h0, p[3:0], 8'h30 + p[7:0]});
			chk("serValid", p != 8, serValid);
			chk("cellWe", p == 8, cellWe);
			if (p != 8) chk("serWord", {p[3:0], 8'h30 + p[7:0]}, {serPort, serData});
		end
	endtask
	task automatic t_subst;
		wr(OFS_VALUE, 32'hA5);
		wr(OFS_TEXT, 32'h80D);
		wr(OFS_TEXT, 32'h801);
		grab(3);
		chk("substN", 32'h2, q.size());
		chk("substHi", {5'h00, 8'h41}, q[0]);
		chk("substLo", {5'h01, 8'h35}, q[1]);
	endtask
	task automatic t_clear;
		wr(OFS_TEXT, 32'h80C);
		grab(40);
		chk("clearN", 32'h20, q.size());
		foreach (q[i]) chk("clearCell", {i[4:0], 8'h20}, q[i]);
		wr(OFS_TEXT, 32'h841);
		grab(1);
		chk("afterClear", {5'h00, 8'h41}, q[0]);
		// a text write during the clear must be dropped, not queued
		wr(OFS_TEXT, 32'h80C);
		wr(OFS_TEXT, 32'h842);
		repeat (40) @(posedge clk);
		rd(OFS_STATUS);
		chk("overrun", 32'h1, d[STAT_OVERRUN_BIT]);
		wr(OFS_CELL_IDX, 32'h00);
		rd(OFS_CELL_DATA);
		chk("dropped", 32'h20, d);
		wr(OFS_STATUS, 32'h100);
		rd(OFS_STATUS);
		chk("overrunClr", 32'h0, d[STAT_OVERRUN_BIT]);
	endtask
	task automatic t_keys;
		int n;
		@(posedge clk);
		key <= 4'h2;
		repeat (2) @(posedge clk);
		key <= 4'h9;
		repeat (10) @(posedge clk);
		#1;
		chk("early", 32'h0, flag);
		n = 0;
		while (flag !== 4'h9 && n < 120) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("flagsOn", 32'h9, flag);
		rd(OFS_KEYS);
		chk("keyWord", 32'h9, d);
		@(posedge clk);
		key <= 4'h0;
		n = 0;
		while (flag !== 4'h0 && n < 120) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("flagsOff", 32'h0, flag);
		rd(OFS_KEYS);
		chk("keyWordOff", 32'h0, d);
	endtask
	task automatic t_prog;
		wr(OFS_STATION, 32'hFF);
		rd(OFS_STATION);
		chk("station", 32'hFF, d);
		pg(8'hFF, 1'b1, 1'b1);
		pg(8'hFE, 1'b1, 1'b0);
		pg(8'h7F, 1'b0, 1'b0);
		wr(OFS_CONFIG, 32'h1);
		pg(8'hFF, 1'b1, 1'b0);
		pg(8'hFF, 1'b0, 1'b1);
		wr(OFS_CONFIG, 32'h0);
		pg(8'hFF, 1'b1, 1'b1);
	endtask
	// ****************
	// main sequence
	// ****************
	initial begin
		srst = 1'b1;
		wrStb = 1'b0;
		rdStb = 1'b0;
		addr = '0;
		wrData = '0;
		key = 4'h0;
		prog = '0;
		errors = 0;
		cmp_count = 0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_row();
		t_cursor();
		t_serial();
		t_subst();
		t_clear();
		t_keys();
		t_prog();
		end_of_test();
	end
	// run needs about 350 cycles; allow well over fifty times that
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
endmodule // tb_front_panel_text_display_keys
